// [inc/txdesc_pkg.sv]
package txdesc_pkg;

    localparam int LEN_MAX_W   = 26;
    localparam int CTL_EOF_BIT = 26;
    localparam int CTL_SOF_BIT = 27;
    localparam int CTL_RSV_LO  = 28;
    localparam int APP_WORDS   = 5;
    localparam int APP_CNT_W   = 3;
    localparam int DATA_W      = 32;
    localparam int KEEP_W      = 4;
    localparam int BEAT_BYTES  = 4;
    localparam int ADDR_W      = 8;
    localparam int IRQ_W       = 3;

    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LAST_CTL = 8'h10;

    localparam int CTRL_RUN_BIT   = 0;
    localparam int STAT_HALT_BIT  = 0;
    localparam int STAT_IDLE_BIT  = 1;
    localparam int IRQ_ERR_BIT    = 0;
    localparam int IRQ_DESC_BIT   = 1;
    localparam int IRQ_PKT_BIT    = 2;

    localparam logic [KEEP_W-1:0]    KEEP_ALL  = 4'hF;
    localparam logic [LEN_MAX_W-1:0] LEN_BEAT  = 26'h0000004;
    localparam logic [LEN_MAX_W-1:0] LEN_ZERO  = 26'h0000000;
    localparam logic [APP_CNT_W-1:0] APP_LAST  = 3'h4;

    typedef enum logic [4:0] {
        S_IDLE    = 5'b00001,
        S_APP     = 5'b00010,
        S_DATA    = 5'b00100,
        S_HALTING = 5'b01000,
        S_HALTED  = 5'b10000
    } tx_state_t;

    typedef struct packed {
        logic [APP_WORDS-1:0][DATA_W-1:0] app;
        logic [DATA_W-1:0]                ctl;
    } desc_t;

    typedef struct packed {
        logic [LEN_MAX_W-1:0] len;
        logic                 sof;
        logic                 eof;
        logic                 zero_len;
    } ctl_fields_t;

    typedef struct packed {
        logic [LEN_MAX_W-1:0] len;
        logic                 sof;
        logic                 eof;
    } cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [KEEP_W-1:0] keep;
        logic              last;
    } beat_t;

endpackage

// [rtl/ctl_word_decode.sv]
`timescale 1ns/10ps
module ctl_word_decode #(
    parameter int LEN_W = txdesc_pkg::LEN_MAX_W
) (
    input  wire logic [txdesc_pkg::DATA_W-1:0] ctl_word,
    output txdesc_pkg::ctl_fields_t            fields
);
    logic [txdesc_pkg::LEN_MAX_W-1:0] len_masked;

    genvar i;
    generate
        for (i = 0; i < txdesc_pkg::LEN_MAX_W; i++) begin : g_len
            // Bits above the built width are ignored
            assign len_masked[i] = (i < LEN_W) ? ctl_word[i] : 1'b0;
        end
    endgenerate

    // Top four bits are not looked at
    assign fields.len      = len_masked;
    assign fields.eof      = ctl_word[txdesc_pkg::CTL_EOF_BIT];
    assign fields.sof      = ctl_word[txdesc_pkg::CTL_SOF_BIT];
    assign fields.zero_len = (len_masked == txdesc_pkg::LEN_ZERO);
endmodule

// [rtl/app_word_sender.sv]
`timescale 1ns/10ps
module app_word_sender (
    input  wire logic                                            mclk,
    input  wire logic                                            rst_b,
    input  wire logic                                            start,
    input  wire logic [txdesc_pkg::APP_WORDS-1:0][txdesc_pkg::DATA_W-1:0] words,
    input  wire logic                                            cs_tready,
    output logic      [txdesc_pkg::DATA_W-1:0]                   cs_tdata,
    output logic                                                 cs_tvalid,
    output logic                                                 cs_tlast,
    output logic                                                 done
);
    typedef struct packed {
        logic [txdesc_pkg::APP_WORDS-1:0][txdesc_pkg::DATA_W-1:0] words;
        logic [txdesc_pkg::APP_CNT_W-1:0]                         cnt;
        logic                                                     busy;
    } snd_state_t;

    snd_state_t q;
    snd_state_t next_q;

    assign cs_tdata  = q.words[0];
    assign cs_tvalid = q.busy;
    assign cs_tlast  = q.busy && (q.cnt == txdesc_pkg::APP_LAST);
    assign done      = cs_tlast && cs_tready;

    always_comb begin
        next_q = q;
        if (start && !q.busy) begin
            next_q.words = words;
            next_q.cnt   = '0;
            next_q.busy  = 1'b1;
        end else if (q.busy && cs_tready) begin
            next_q.words = {{txdesc_pkg::DATA_W{1'b0}},
                            q.words[txdesc_pkg::APP_WORDS-1:1]};
            next_q.cnt   = q.cnt + 3'h1;
            if (cs_tlast) begin
                next_q.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule

// [rtl/tx_desc_engine.sv]
`timescale 1ns/10ps
module tx_desc_engine #(
    parameter int LEN_W          = txdesc_pkg::LEN_MAX_W,
    parameter bit CTRL_STREAM_EN = 1'b1
) (
    input  wire logic                              mclk,
    input  wire logic                              rst_b,
    input  wire logic [txdesc_pkg::ADDR_W-1:0]     reg_addr,
    input  wire logic [txdesc_pkg::DATA_W-1:0]     reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [txdesc_pkg::DATA_W-1:0]     reg_rdata,
    output logic                                   irq,
    input  wire logic                              desc_valid,
    input  wire txdesc_pkg::desc_t                 desc,
    output logic                                   desc_ready,
    output logic                                   app_fetch_en,
    output txdesc_pkg::cmd_t                       cmd,
    output logic                                   cmd_valid,
    input  wire logic [txdesc_pkg::DATA_W-1:0]     mover_data,
    input  wire logic                              mover_valid,
    output logic                                   mover_ready,
    output txdesc_pkg::beat_t                      tx_beat,
    output logic                                   tx_tvalid,
    input  wire logic                              tx_tready,
    output logic      [txdesc_pkg::DATA_W-1:0]     cs_tdata,
    output logic                                   cs_tvalid,
    output logic                                   cs_tlast,
    input  wire logic                              cs_tready
);
    typedef struct packed {
        txdesc_pkg::tx_state_t            st;
        logic                             run;
        logic [txdesc_pkg::IRQ_W-1:0]     irq_stat;
        logic [txdesc_pkg::IRQ_W-1:0]     irq_mask;
        logic [txdesc_pkg::LEN_MAX_W-1:0] remaining;
        logic                             eof;
        logic [txdesc_pkg::DATA_W-1:0]    ctl_word;
        txdesc_pkg::cmd_t                 cmd;
        logic                             cmd_valid;
        txdesc_pkg::beat_t                beat;
        logic                             beat_valid;
        logic [txdesc_pkg::DATA_W-1:0]    rdata;
    } eng_state_t;

    eng_state_t                  q;
    eng_state_t                  next_q;
    txdesc_pkg::ctl_fields_t     fields;
    logic                        app_start;
    logic                        app_done;
    logic                        take_desc;
    logic                        take_beat;
    logic                        last_of_buf;
    logic [2:0]                  keep_shift;
    logic [txdesc_pkg::IRQ_W-1:0] ev;
    logic [txdesc_pkg::IRQ_W-1:0] clr;

    ctl_word_decode #(
        .LEN_W    (LEN_W)
    ) u_decode (
        .ctl_word (desc.ctl),
        .fields   (fields)
    );

    app_word_sender u_app (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .start     (app_start),
        .words     (desc.app),
        .cs_tready (cs_tready),
        .cs_tdata  (cs_tdata),
        .cs_tvalid (cs_tvalid),
        .cs_tlast  (cs_tlast),
        .done      (app_done)
    );

    assign app_fetch_en = CTRL_STREAM_EN;
    assign desc_ready   = (q.st == txdesc_pkg::S_IDLE) && q.run;
    assign take_desc    = desc_valid && desc_ready;
    assign app_start    = take_desc && !fields.zero_len && fields.sof
                          && CTRL_STREAM_EN;
    assign mover_ready  = (q.st == txdesc_pkg::S_DATA)
                          && (!q.beat_valid || tx_tready);
    assign take_beat    = mover_valid && mover_ready;
    assign last_of_buf  = (q.remaining <= txdesc_pkg::LEN_BEAT);
    assign keep_shift   = 3'(txdesc_pkg::BEAT_BYTES)
                          - q.remaining[2:0];
    assign cmd          = q.cmd;
    assign cmd_valid    = q.cmd_valid;
    assign tx_beat      = q.beat;
    assign tx_tvalid    = q.beat_valid;
    assign reg_rdata    = q.rdata;
    assign irq          = |(q.irq_stat & q.irq_mask);

    always_comb begin
        next_q           = q;
        ev               = '0;
        clr              = '0;
        next_q.cmd_valid = 1'b0;
        next_q.rdata     = '0;
        if (q.beat_valid && tx_tready) begin
            next_q.beat_valid = 1'b0;
        end
        case (q.st)
            txdesc_pkg::S_IDLE: begin
                if (!q.run) begin
                    // A held beat must drain before the halt is reported
                    next_q.st = txdesc_pkg::S_HALTING;
                end else if (take_desc) begin
                    next_q.ctl_word = desc.ctl;
                    if (fields.zero_len) begin
                        ev[txdesc_pkg::IRQ_ERR_BIT] = 1'b1;
                        next_q.run = 1'b0;
                        next_q.st  = txdesc_pkg::S_HALTING;
                    end else begin
                        next_q.remaining = fields.len;
                        next_q.eof       = fields.eof;
                        next_q.cmd.len   = fields.len;
                        next_q.cmd.sof   = fields.sof;
                        next_q.cmd.eof   = fields.eof;
                        next_q.cmd_valid = 1'b1;
                        // Control words precede the first buffer
                        next_q.st = app_start ? txdesc_pkg::S_APP
                                              : txdesc_pkg::S_DATA;
                    end
                end
            end
            txdesc_pkg::S_APP: begin
                if (app_done) begin
                    next_q.st = txdesc_pkg::S_DATA;
                end
            end
            txdesc_pkg::S_DATA: begin
                if (take_beat) begin
                    next_q.beat.data  = mover_data;
                    next_q.beat.keep  = last_of_buf
                                        ? (txdesc_pkg::KEEP_ALL >> keep_shift)
                                        : txdesc_pkg::KEEP_ALL;
                    next_q.beat.last  = q.eof && last_of_buf;
                    next_q.beat_valid = 1'b1;
                    next_q.remaining  = last_of_buf ? txdesc_pkg::LEN_ZERO
                                        : q.remaining - txdesc_pkg::LEN_BEAT;
                    if (last_of_buf) begin
                        ev[txdesc_pkg::IRQ_DESC_BIT] = 1'b1;
                        ev[txdesc_pkg::IRQ_PKT_BIT]  = q.eof;
                        next_q.st = txdesc_pkg::S_IDLE;
                    end
                end
            end
            txdesc_pkg::S_HALTING: begin
                // Let the last beat drain before reporting the halt
                if (!q.beat_valid) begin
                    next_q.st = txdesc_pkg::S_HALTED;
                end
            end
            txdesc_pkg::S_HALTED: begin
                if (q.run) begin
                    next_q.st = txdesc_pkg::S_IDLE;
                end
            end
            default: begin
                next_q.st = txdesc_pkg::S_IDLE;
            end
        endcase
        if (reg_wr) begin
            if (reg_addr == txdesc_pkg::OFS_CTRL) begin
                next_q.run = reg_wdata[txdesc_pkg::CTRL_RUN_BIT];
            end else if (reg_addr == txdesc_pkg::OFS_IRQ_STAT) begin
                clr = reg_wdata[txdesc_pkg::IRQ_W-1:0];
            end else if (reg_addr == txdesc_pkg::OFS_IRQ_MASK) begin
                next_q.irq_mask = reg_wdata[txdesc_pkg::IRQ_W-1:0];
            end
        end
        // A new event wins over a clear in the same cycle
        next_q.irq_stat = (q.irq_stat & ~clr) | ev;
        if (reg_rd) begin
            if (reg_addr == txdesc_pkg::OFS_CTRL) begin
                next_q.rdata[txdesc_pkg::CTRL_RUN_BIT] = q.run;
            end else if (reg_addr == txdesc_pkg::OFS_STATUS) begin
                next_q.rdata[txdesc_pkg::STAT_HALT_BIT] =
                    (q.st == txdesc_pkg::S_HALTED);
                next_q.rdata[txdesc_pkg::STAT_IDLE_BIT] =
                    (q.st == txdesc_pkg::S_IDLE);
            end else if (reg_addr == txdesc_pkg::OFS_IRQ_STAT) begin
                next_q.rdata[txdesc_pkg::IRQ_W-1:0] = q.irq_stat;
            end else if (reg_addr == txdesc_pkg::OFS_IRQ_MASK) begin
                next_q.rdata[txdesc_pkg::IRQ_W-1:0] = q.irq_mask;
            end else if (reg_addr == txdesc_pkg::OFS_LAST_CTL) begin
                next_q.rdata = q.ctl_word;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            q    <= '0;
            q.st <= txdesc_pkg::S_IDLE;
        end else begin
            q <= next_q;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    AST_LEN_TO_CMD: assert property (
        take_desc && !fields.zero_len |=> cmd_valid
            && cmd.len == $past(desc.ctl[LEN_W-1:0]))
        else $error("command length differs from descriptor");

    AST_KEEP_FULL: assert property (
        take_beat && !last_of_buf |=> tx_beat.keep == txdesc_pkg::KEEP_ALL)
        else $error("inner beat lost byte enables");

    AST_LEN_WIDTH: assert property (
        cmd_valid |-> (cmd.len >> LEN_W) == '0)
        else $error("length bits above built width used");

    AST_EOF_FLAG: assert property (
        take_desc && !fields.zero_len |=> cmd.eof
            == $past(desc.ctl[txdesc_pkg::CTL_EOF_BIT]))
        else $error("end flag not taken from bit 26");

    AST_DONE_IDLE: assert property (
        take_beat && last_of_buf |=> q.st == txdesc_pkg::S_IDLE)
        else $error("buffer end did not free the engine");

    AST_SOF_FLAG: assert property (
        take_desc && !fields.zero_len |=> cmd.sof
            == $past(desc.ctl[txdesc_pkg::CTL_SOF_BIT]))
        else $error("start flag not taken from bit 27");

    AST_ONE_BUF: assert property (
        take_desc && fields.sof && fields.eof && !fields.zero_len
            |=> cmd_valid && cmd.sof && cmd.eof)
        else $error("single buffer packet lost a flag");

    AST_APP_FIRST: assert property (
        app_start |=> (q.st == txdesc_pkg::S_APP) && !mover_ready
            && cs_tvalid && cs_tdata == $past(desc.app[0]))
        else $error("control words not sent before data");

    AST_CS_END: assert property (
        cs_tvalid && cs_tready && cs_tlast
            |=> !cs_tvalid && q.st == txdesc_pkg::S_DATA)
        else $error("data phase did not follow control words");

    AST_RSV_IGNORED: assert property (
        take_desc |=> cmd_valid == ($past(desc.ctl[LEN_W-1:0]) != '0))
        else $error("reserved bits changed the command");

    AST_ZERO_ERR: assert property (
        take_desc && fields.zero_len |=> q.st == txdesc_pkg::S_HALTING
            && q.irq_stat[txdesc_pkg::IRQ_ERR_BIT] && !q.run && !cmd_valid)
        else $error("zero length did not halt with error");

    AST_HALT_DONE: assert property (
        q.st == txdesc_pkg::S_HALTING && !tx_tvalid
            |=> q.st == txdesc_pkg::S_HALTED)
        else $error("halt not reported after drain");

    AST_HALT_QUIET: assert property (
        q.st == txdesc_pkg::S_HALTED |-> !tx_tvalid && !cmd_valid
            && !cs_tvalid)
        else $error("activity while halted");

    AST_ERR_STICKY: assert property (
        q.irq_stat[txdesc_pkg::IRQ_ERR_BIT]
            && !(reg_wr && reg_addr == txdesc_pkg::OFS_IRQ_STAT)
            |=> q.irq_stat[txdesc_pkg::IRQ_ERR_BIT])
        else $error("error flag dropped without a clear");

    AST_NO_APP: assert property (
        !CTRL_STREAM_EN |-> !cs_tvalid && !app_fetch_en)
        else $error("app words used without control stream");

    AST_LAST_BEAT: assert property (
        take_beat |=> tx_beat.last == ($past(q.eof)
            && $past(last_of_buf)))
        else $error("last flag on wrong beat");

    AST_BEAT_HOLD: assert property (
        tx_tvalid && !tx_tready |=> tx_tvalid && $stable(tx_beat))
        else $error("stream beat changed while stalled");

    AST_READ_ONE: assert property (
        !reg_rd |=> reg_rdata == '0)
        else $error("read data stood beyond one cycle");

    COV_SINGLE: cover property (
        take_desc && fields.sof && fields.eof && !fields.zero_len);
    COV_APP: cover property (app_done);
    COV_ERR: cover property (take_desc && fields.zero_len);
    COV_LAST: cover property (tx_tvalid && tx_tready && tx_beat.last);
    COV_STALL: cover property (tx_tvalid && !tx_tready);
endmodule

// [bench/mover_model.sv]
`timescale 1ns/10ps
module mover_model (
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    input  wire logic                          stall,
    input  wire logic                          mover_ready,
    output logic      [txdesc_pkg::DATA_W-1:0] mover_data,
    output logic                               mover_valid,
    output logic                               tx_tready,
    output logic                               cs_tready
);
    logic [3:0]  tick;
    logic [31:0] word;
    logic        offer;

    assign offer     = !stall || tick[1];
    assign tx_tready = !stall || tick[0];
    assign cs_tready = !stall || tick[2];

    // Words count up from a base; an idle data line shows the inverse
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tick        <= 4'h0;
            word        <= 32'h00001000;
            mover_valid <= 1'b0;
            mover_data  <= 32'h00000000;
        end else begin
            tick <= tick + 4'h1;
            if (!mover_valid || mover_ready) begin
                mover_valid <= offer;
                mover_data  <= offer ? word : ~mover_data;
                if (offer) begin
                    word <= word + 32'h1;
                end
            end
        end
    end
endmodule

// [bench/testbench.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    error_cnt++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
    localparam int LW = 8;
    logic                    mclk = 1'b0;
    logic                    rst_b = 1'b0;
    logic [7:0]              reg_addr = 8'h00;
    logic [31:0]             reg_wdata = 32'h0;
    logic                    reg_wr = 1'b0;
    logic                    reg_rd = 1'b0;
    logic [31:0]             reg_rdata;
    logic                    irq;
    logic                    desc_valid = 1'b0;
    txdesc_pkg::desc_t       desc = '0;
    logic                    desc_ready;
    logic                    app_fetch_en;
    txdesc_pkg::cmd_t        cmd;
    txdesc_pkg::cmd_t        got_cmd;
    logic                    cmd_valid;
    logic [31:0]             mover_data;
    logic                    mover_valid;
    logic                    mover_ready;
    txdesc_pkg::beat_t       tx_beat;
    txdesc_pkg::beat_t       txq[$];
    logic                    tx_tvalid;
    logic                    tx_tready;
    logic [31:0]             cs_tdata;
    logic                    cs_tvalid;
    logic                    cs_tlast;
    logic                    cs_tready;
    logic [32:0]             csq[$];
    logic                    stall = 1'b0;
    logic                    nocs_fetch;
    logic                    nocs_cs_valid;
    logic                    nocs_cs_seen = 1'b0;
    logic [31:0]             word_exp = 32'h00001000;
    logic [31:0]             tbl[3] = '{32'h08000008, 32'h00000004,
                                        32'h04000105};
    int                      cmd_seen = 0;
    int                      cycles = 0;
    int                      error_cnt = 0;
    int                      check_count = 0;

    always #5 mclk = ~mclk;

    tx_desc_engine #(.LEN_W(LW), .CTRL_STREAM_EN(1'b1)) dut_u (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .desc_valid(desc_valid),
        .desc(desc), .desc_ready(desc_ready), .app_fetch_en(app_fetch_en),
        .cmd(cmd), .cmd_valid(cmd_valid), .mover_data(mover_data),
        .mover_valid(mover_valid), .mover_ready(mover_ready),
        .tx_beat(tx_beat), .tx_tvalid(tx_tvalid), .tx_tready(tx_tready),
        .cs_tdata(cs_tdata), .cs_tvalid(cs_tvalid), .cs_tlast(cs_tlast),
        .cs_tready(cs_tready));

    mover_model far_u (
        .mclk(mclk), .rst_b(rst_b), .stall(stall),
        .mover_ready(mover_ready), .mover_data(mover_data),
        .mover_valid(mover_valid), .tx_tready(tx_tready),
        .cs_tready(cs_tready));

    // Build without the control stream; app words must stay unused
    tx_desc_engine #(.LEN_W(LW), .CTRL_STREAM_EN(1'b0)) nocs_u (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(), .irq(), .desc_valid(desc_valid),
        .desc(desc), .desc_ready(), .app_fetch_en(nocs_fetch),
        .cmd(), .cmd_valid(), .mover_data(mover_data),
        .mover_valid(mover_valid), .mover_ready(),
        .tx_beat(), .tx_tvalid(), .tx_tready(1'b1),
        .cs_tdata(), .cs_tvalid(nocs_cs_valid), .cs_tlast(),
        .cs_tready(1'b1));

    always @(posedge mclk) begin
        if (cmd_valid === 1'b1) begin
            got_cmd = cmd;
            cmd_seen++;
        end
        if (tx_tvalid && tx_tready) txq.push_back(tx_beat);
        if (cs_tvalid && cs_tready) csq.push_back({cs_tlast, cs_tdata});
        if (rst_b && nocs_cs_valid !== 1'b0) nocs_cs_seen = 1'b1;
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        `CHK(nm, e, reg_rdata)
    endtask

    // Offer one descriptor, wait for its buffer, then compare both streams
    task automatic run_desc(input logic [31:0] ctl);
        txdesc_pkg::desc_t d;
        logic [25:0]       len;
        logic [3:0]        k;
        int                n;
        int                rem;
        int                i;
        len = ctl[25:0] & 26'(2**LW - 1);
        n = (int'(len) + 3) / 4;
        d.ctl = ctl;
        for (i = 0; i < 5; i++) d.app[i] = 32'hA0000000 + ctl + 32'(i);
        txq.delete();
        csq.delete();
        cmd_seen = 0;
        desc       <= d;
        desc_valid <= 1'b1;
        i = 0;
        do @(posedge mclk); while (desc_ready !== 1'b1 && ++i < 50);
        desc_valid <= 1'b0;
        if (len == 26'h0) begin
            repeat (20) @(posedge mclk);
            `CHK("zero_cmd", 0, cmd_seen)
            return;
        end
        i = 0;
        do @(posedge mclk); while (desc_ready !== 1'b1 && ++i < 400);
        // Let a stalled final beat reach the collector
        repeat (2) @(posedge mclk);
        `CHK("done", 1'b1, desc_ready)
        `CHK("cmd_cnt", 1, cmd_seen)
        `CHK("cmd_len", len, got_cmd.len)
        `CHK("cmd_sof", ctl[27], got_cmd.sof)
        `CHK("cmd_eof", ctl[26], got_cmd.eof)
        `CHK("cs_beats", ctl[27] ? 5 : 0, csq.size())
        foreach (csq[j])
            `CHK("cs_word", {j == 4, 32'hA0000000 + ctl + 32'(j)}, csq[j])
        `CHK("tx_beats", n, txq.size())
        foreach (txq[j]) begin
            rem = int'(len) - 4 * j;
            k = rem >= 4 ? 4'hF : 4'hF >> (4 - rem);
            `CHK("tx_data", word_exp, txq[j].data)
            word_exp++;
            `CHK("tx_keep", k, txq[j].keep)
            `CHK("tx_last", ctl[26] && j == n - 1, txq[j].last)
        end
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd_chk("ctrl_rst", txdesc_pkg::OFS_CTRL, 32'h0);
        rd_chk("stat_rst", txdesc_pkg::OFS_IRQ_STAT, 32'h0);
        rd_chk("mask_rst", txdesc_pkg::OFS_IRQ_MASK, 32'h0);
        rd_chk("unmapped", 8'h14, 32'h0);
        rd_chk("halted", txdesc_pkg::OFS_STATUS, 32'h1);
        `CHK("app_fetch", 1'b1, app_fetch_en)
        $display("test reset done");
        reg_write(txdesc_pkg::OFS_IRQ_MASK, 32'h7);
        reg_write(txdesc_pkg::OFS_CTRL, 32'h1);
        run_desc(32'hFC000006);
        `CHK("irq_on", 1'b1, irq)
        rd_chk("irq_pkt", txdesc_pkg::OFS_IRQ_STAT, 32'h6);
        reg_write(txdesc_pkg::OFS_IRQ_STAT, 32'h6);
        rd_chk("irq_clr", txdesc_pkg::OFS_IRQ_STAT, 32'h0);
        `CHK("irq_off", 1'b0, irq)
        `CHK("nocs_fetch", 1'b0, nocs_fetch)
        `CHK("nocs_cs", 1'b0, nocs_cs_seen)
        $display("test single buffer done");
        stall <= 1'b1;
        // One start, one plain, one end buffer; short lengths
        foreach (tbl[j]) begin
            run_desc(tbl[j]);
            if (j == 0)
                rd_chk("irq_mid", txdesc_pkg::OFS_IRQ_STAT, 32'h2);
        end
        rd_chk("irq_end", txdesc_pkg::OFS_IRQ_STAT, 32'h6);
        reg_write(txdesc_pkg::OFS_IRQ_STAT, 32'h6);
        $display("test three buffers done");
        reg_write(txdesc_pkg::OFS_IRQ_MASK, 32'h0);
        run_desc(32'h0C000100);
        `CHK("irq_mask", 1'b0, irq)
        rd_chk("err_flag", txdesc_pkg::OFS_IRQ_STAT, 32'h1);
        rd_chk("run_clr", txdesc_pkg::OFS_CTRL, 32'h0);
        rd_chk("err_halt", txdesc_pkg::OFS_STATUS, 32'h1);
        `CHK("no_accept", 1'b0, desc_ready)
        reg_write(txdesc_pkg::OFS_IRQ_MASK, 32'h1);
        `CHK("irq_unmask", 1'b1, irq)
        reg_write(txdesc_pkg::OFS_IRQ_STAT, 32'h1);
        `CHK("irq_w1c", 1'b0, irq)
        $display("test zero length done");
        conclude();
    end
endmodule
